// ==== include/ubg_pkg.sv ====
// constants and types shared by the baud generator and transmit status block
package ubg_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_MODE = 16'hff50;
  localparam logic [15:0] IDX_TX_STATUS = 16'hff55;
  localparam logic [15:0] IDX_BASE_CLOCK_SELECT = 16'hff56;
  localparam logic [15:0] IDX_BAUD_DIVIDER = 16'hff57;
  localparam logic [15:0] IDX_TRANSMIT_BUFFER = 16'hff5a;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int POWER_ENABLE_BIT = 7;
  localparam int TRANSMIT_ENABLE_BIT = 6;
  localparam int RECEIVE_ENABLE_BIT = 5;
  localparam int BUFFER_FULL_BIT = 1;
  localparam int SHIFT_BUSY_BIT = 0;
  localparam int CLOCK_SELECT_W = 4;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] TX_STATUS_RESET = 8'h00;
  localparam logic [3:0] CLOCK_SELECT_RESET = 4'h0;
  localparam logic [7:0] BAUD_DIVIDER_RESET = 8'hff;

  // ----------------------------------------------------------------------
  // clock select codes and counts
  // ----------------------------------------------------------------------
  localparam logic [3:0] CKSEL_LAST_DIV = 4'ha;
  localparam logic [3:0] CKSEL_TIMER = 4'hb;
  localparam int PRESCALE_W = 10;
  localparam int DIVIDER_W = 8;
  localparam int DIVIDER_MIN = 8;
  localparam logic [3:0] FRAME_LAST = 4'h9;

  typedef logic [3:0] ubg_cksel_type;
  typedef logic [31:0] ubg_word_type;

  // transmit sequencer states
  typedef enum logic
  {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } ubg_tx_state_type;

endpackage

// ==== src/ubg_prescaler.sv ====
// base clock prescaler: power-of-two divide or timer output edge
`timescale 1ns/1ps
module ubg_prescaler
#(
  parameter int PRE_W = 10
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire ubg_pkg::ubg_cksel_type sel,
  input wire logic timer_pin,
  output logic base_tick
);
  import ubg_pkg::*;

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] mask;
  logic timer_s1_q;
  logic timer_s2_q;
  logic timer_prev_q;
  logic tick_d;

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (PRE_W < PRESCALE_W)
  begin : g_chk
    $error("prescaler too narrow for the largest divide code");
  end

  // timer output is a pin: two flops before any logic looks at it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_s1_q <= 1'b0;
      timer_s2_q <= 1'b0;
      timer_prev_q <= 1'b0;
    end
    else
    begin
      timer_s1_q <= timer_pin;
      timer_s2_q <= timer_s1_q;
      timer_prev_q <= timer_s2_q;
    end
  end

  // free running count; cleared while powered off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_q <= '0;
    else if (!run)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  // low sel bits of the count all ones gives hclk / 2**sel
  always_comb
  begin
    for (int i = 0; i < PRE_W; i++)
      mask[i] = (i < int'(sel));
    if (sel == CKSEL_TIMER)
      tick_d = timer_s2_q && !timer_prev_q; // RQ8
    else if (sel > CKSEL_LAST_DIV)
      tick_d = 1'b0; // prohibited codes stall the unit
    else
      tick_d = (pre_q & mask) == mask; // RQ7
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      base_tick <= 1'b0;
    else
      base_tick <= run && tick_d;
  end

endmodule

// ==== src/ubg_top.sv ====
// baud rate generator, transmit buffer and status with an AHB-Lite slave
//
// Function
// RQ1 - buffer-full reads 0 when off or disabled; clears on transfer to shifter
// RQ2 - buffer-full sets when software writes the transmit buffer
// RQ3 - shift-busy sets on transfer to shifter, stays set during the character
// RQ4 - shift-busy clears when off, disabled, or frame ends with nothing buffered
// RQ5 - host writes next byte only after buffer-full reads 0
// RQ6 - host waits for shift-busy 0 before reinitialising the transmitter
// RQ7 - clock select codes 0 to 10 give system clock over two to the code
// RQ8 - code 1011 selects timer output; higher codes are prohibited
// RQ9 - host changes clock select only while power-enable is 0
// RQ10 - rewriting same select or divider value does not disturb traffic
// RQ11 - divider value k from 8 to 255 divides base clock by k
// RQ12 - bit rate is the divider output halved
// RQ13 - host rewrites divider only with transmit and receive disabled
// RQ14 - divider register resets to all ones
// RQ15 - clock select register resets to zero
// RQ16 - status clears on reset and when power or transmit enable drops
// RQ17 - divider output becomes active at second base clock after power-on
// RQ18 - power off stops clock and resets unit; transmit off resets transmitter
// RQ19 - divider pulses once every k base clocks, restarts when powered off
// RQ20 - status read-only, upper six bits zero, buffer-full bit 1, busy bit 0
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module ubg_top
#(
  parameter int DIV_W = 8,
  parameter int PRE_W = 10
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire ubg_pkg::ubg_word_type haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire ubg_pkg::ubg_word_type hwdata,
  input wire logic hready,
  output ubg_pkg::ubg_word_type hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic eight_bit_timer_out,
  output logic txd
);
  import ubg_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (DIV_W != DIVIDER_W)
  begin : g_chk
    $error("divider width must match the 8-bit divider register");
  end

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic addr_phase;
  logic wr_pend_q;
  ubg_word_type wr_addr_q;
  ubg_word_type rd_d;
  logic [7:0] mode_q;
  ubg_cksel_type base_clock_select_q;
  logic [7:0] baud_divider_q;
  logic [7:0] transmit_buffer_q;
  logic buffer_full_flag_q;
  ubg_tx_state_type tx_state_q;
  logic [8:0] transmit_shifter_q;
  logic [3:0] bit_cnt_q;
  logic warm_q;
  logic [7:0] div_cnt_q;
  logic div_tick_q;
  logic half_q;
  logic bit_tick_q;
  logic base_tick;
  logic power_enable;
  logic transmit_enable;
  logic tx_active;
  logic buf_wr;
  logic frame_end;
  logic load;
  logic [7:0] tx_status;

  // true when a word address lands on a register index
  function automatic logic reg_at(input ubg_word_type a,
                                  input logic [15:0] idx);
    reg_at = (a == {14'h0, idx, 2'b00});
  endfunction

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  assign addr_phase = hsel && hready && htrans[1];

  // write address held for the data phase; hsize is not checked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase)
        wr_addr_q <= haddr;
    end
  end

  // read mux; unmapped and write-only words read zero
  always_comb
  begin
    rd_d = '0;
    if (reg_at(haddr, IDX_MODE))
      rd_d[7:0] = mode_q;
    else if (reg_at(haddr, IDX_TX_STATUS))
      rd_d[7:0] = tx_status; // RQ20
    else if (reg_at(haddr, IDX_BASE_CLOCK_SELECT))
      rd_d[CLOCK_SELECT_W-1:0] = base_clock_select_q;
    else if (reg_at(haddr, IDX_BAUD_DIVIDER))
      rd_d[7:0] = baud_divider_q;
  end

  // read data is latched at the end of the address phase, no wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (addr_phase && !hwrite)
      hrdata <= rd_d;
    else
      hrdata <= '0;
  end

  // always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------

  // mode register: power, transmit and receive enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode_q <= MODE_RESET;
    else if (wr_pend_q && reg_at(wr_addr_q, IDX_MODE))
      mode_q <= hwdata[7:0];
  end

  assign power_enable = mode_q[POWER_ENABLE_BIT];
  assign transmit_enable = mode_q[TRANSMIT_ENABLE_BIT];
  assign tx_active = power_enable && transmit_enable;

  // select takes effect at once; changing it live glitches the base clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      base_clock_select_q <= CLOCK_SELECT_RESET; // RQ15
    else if (wr_pend_q && reg_at(wr_addr_q, IDX_BASE_CLOCK_SELECT))
      base_clock_select_q <= hwdata[CLOCK_SELECT_W-1:0]; // RQ10
  end

  // a write touches no counter, so an equal value changes nothing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      baud_divider_q <= BAUD_DIVIDER_RESET; // RQ14
    else if (wr_pend_q && reg_at(wr_addr_q, IDX_BAUD_DIVIDER))
      baud_divider_q <= hwdata[7:0]; // RQ10
  end

  // ----------------------------------------------------------------------
  // base clock and baud divider
  // ----------------------------------------------------------------------
  ubg_prescaler #(
    .PRE_W(PRE_W)
  ) u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(power_enable),
    .sel(base_clock_select_q),
    .timer_pin(eight_bit_timer_out),
    .base_tick(base_tick)
  );

  // first base tick after power-on only arms the counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      warm_q <= 1'b0;
    else if (!power_enable)
      warm_q <= 1'b0; // RQ18
    else if (base_tick)
      warm_q <= 1'b1; // RQ17
  end

  // k base ticks per pulse; >= keeps a shrunk value from wrapping 256
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt_q <= '0;
      div_tick_q <= 1'b0;
    end
    else if (!power_enable)
    begin
      div_cnt_q <= '0; // RQ19
      div_tick_q <= 1'b0;
    end
    else
    begin
      div_tick_q <= 1'b0;
      if (base_tick && warm_q)
      begin
        if (div_cnt_q >= baud_divider_q - 8'h01)
        begin
          div_cnt_q <= '0; // RQ11
          div_tick_q <= 1'b1; // RQ19
        end
        else
          div_cnt_q <= div_cnt_q + 8'h01;
      end
    end
  end

  // halve the divider output to get one pulse per bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      half_q <= 1'b0;
      bit_tick_q <= 1'b0;
    end
    else if (!power_enable)
    begin
      half_q <= 1'b0;
      bit_tick_q <= 1'b0;
    end
    else
    begin
      bit_tick_q <= div_tick_q && half_q; // RQ12
      if (div_tick_q)
        half_q <= !half_q;
    end
  end

  // ----------------------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------------------
  assign buf_wr = wr_pend_q && reg_at(wr_addr_q, IDX_TRANSMIT_BUFFER) &&
                  tx_active;
  assign frame_end = (tx_state_q == TX_SEND) && bit_tick_q &&
                     (bit_cnt_q == FRAME_LAST);
  // loads fall on bit ticks so the start bit is a whole bit long
  assign load = buffer_full_flag_q && bit_tick_q &&
                ((tx_state_q == TX_IDLE) || frame_end);

  // writing while full overwrites the pending byte
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      transmit_buffer_q <= '0;
    else if (buf_wr)
      transmit_buffer_q <= hwdata[7:0];
  end

  // a write in the cycle of a transfer wins over the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      buffer_full_flag_q <= 1'b0; // RQ16
    else if (!tx_active)
      buffer_full_flag_q <= 1'b0; // RQ1
    else if (buf_wr)
      buffer_full_flag_q <= 1'b1; // RQ2
    else if (load)
      buffer_full_flag_q <= 1'b0; // RQ1
  end

  // ----------------------------------------------------------------------
  // transmit shifter: start, eight data bits lsb first, one stop
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_state_q <= TX_IDLE;
    else if (!tx_active)
      tx_state_q <= TX_IDLE; // RQ4
    else
    begin
      unique case (tx_state_q)
        TX_IDLE:
          if (load)
            tx_state_q <= TX_SEND; // RQ3
        TX_SEND:
          if (frame_end && !load)
            tx_state_q <= TX_IDLE; // RQ4
      endcase
    end
  end

  // shift data and count bits; disable resets the transmitter in step
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      transmit_shifter_q <= '0;
      bit_cnt_q <= '0;
    end
    else if (!tx_active)
    begin
      transmit_shifter_q <= '0; // RQ18
      bit_cnt_q <= '0;
    end
    else if (load)
    begin
      transmit_shifter_q <= {1'b1, transmit_buffer_q}; // RQ3
      bit_cnt_q <= '0;
    end
    else if (tx_state_q == TX_SEND && bit_tick_q)
    begin
      transmit_shifter_q <= {1'b0, transmit_shifter_q[8:1]};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // line idles high, and is held high while off or disabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      txd <= 1'b1;
    else if (!tx_active)
      txd <= 1'b1;
    else if (load)
      txd <= 1'b0;
    else if (tx_state_q == TX_SEND && bit_tick_q)
    begin
      if (bit_cnt_q == FRAME_LAST)
        txd <= 1'b1;
      else
        txd <= transmit_shifter_q[0];
    end
  end

  // ----------------------------------------------------------------------
  // status view
  // ----------------------------------------------------------------------
  always_comb
  begin
    tx_status = TX_STATUS_RESET; // RQ20
    tx_status[BUFFER_FULL_BIT] = buffer_full_flag_q && tx_active; // RQ1
    tx_status[SHIFT_BUSY_BIT] = (tx_state_q == TX_SEND) && tx_active; // RQ4
  end

endmodule

// ==== verification/ubg_top_sva.sv ====
// assertions on the bus and serial pins of the baud generator
`timescale 1ns/1ps
module ubg_top_sva
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire ubg_pkg::ubg_word_type haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire ubg_pkg::ubg_word_type hwdata,
  input wire logic hready,
  input wire ubg_pkg::ubg_word_type hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic txd
);
  import ubg_pkg::*;
  logic wr_q, on_q, txd_q, rd;
  logic [15:0] idx_q, ai;
  logic [7:0] k_q;
  logic [3:0] cs_q;
  logic [1:0] on_cnt_q, off_cnt_q;
  logic [31:0] len_q, per;
  // read request decode and bit period of the divided codes
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign ai = haddr[17:2];
  assign per = {23'h0, k_q, 1'b0} << cs_q;
  // address of the write now in its data phase
  always_ff @(posedge hclk)
  begin
    idx_q <= ai;
  end
  // shadow of the control registers as seen from the bus
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      on_q <= 1'b0;
      k_q <= BAUD_DIVIDER_RESET;
      cs_q <= CLOCK_SELECT_RESET;
    end
    else
    begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      if (wr_q && idx_q == IDX_MODE)
        on_q <= hwdata[POWER_ENABLE_BIT] && hwdata[TRANSMIT_ENABLE_BIT];
      if (wr_q && idx_q == IDX_BAUD_DIVIDER)
        k_q <= hwdata[7:0];
      if (wr_q && idx_q == IDX_BASE_CLOCK_SELECT)
        cs_q <= hwdata[3:0];
    end
  end
  // run lengths; the short counters cover the one-cycle-late unit reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      on_cnt_q <= 2'h0;
      off_cnt_q <= 2'h0;
      len_q <= 32'h0;
      txd_q <= 1'b1;
    end
    else
    begin
      on_cnt_q <= !on_q ? 2'h0 : on_cnt_q + {1'b0, on_cnt_q != 2'h3};
      off_cnt_q <= on_q ? 2'h0 : off_cnt_q + {1'b0, off_cnt_q != 2'h3};
      len_q <= (txd != txd_q) ? 32'h1 : len_q + 32'h1;
      txd_q <= txd;
    end
  end
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_okay:
    assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_quiet:
    assert property (!rd |=> hrdata == 32'h0)
    else $error("read data outside a read");
  a_status_upper:
    assert property (rd && ai == IDX_TX_STATUS |=> hrdata[31:2] == 30'h0)
    else $error("status upper bits set");
  a_status_off:
    assert property (rd && ai == IDX_TX_STATUS && off_cnt_q == 2'h3
      |=> hrdata == 32'h0)
    else $error("status set while disabled");
  a_idle_high:
    assert property (off_cnt_q == 2'h3 |-> txd)
    else $error("txd low while disabled");
  a_bit_period:
    assert property (on_cnt_q == 2'h3 && cs_q <= CKSEL_LAST_DIV && $rose(txd)
      |-> len_q % per == 32'h0)
    else $error("low run not whole bit periods");
  a_low_bounded:
    assert property (on_cnt_q == 2'h3 && cs_q <= CKSEL_LAST_DIV && !txd &&
      !txd_q |-> len_q < per * 9)
    else $error("txd low too long");
  a_divider_read:
    assert property (rd && ai == IDX_BAUD_DIVIDER |=> hrdata == {24'h0, k_q})
    else $error("divider read wrong");
  a_select_read:
    assert property (rd && ai == IDX_BASE_CLOCK_SELECT
      |=> hrdata == {28'h0, cs_q})
    else $error("clock select read wrong");
endmodule
bind ubg_top ubg_top_sva chk
(
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .txd
);

// ==== verification/ubg_line_rx.sv ====
// serial line receiver standing at the far end of txd
`timescale 1ns/1ps
module ubg_line_rx
(
  input wire logic clk,
  input wire logic rxd,
  input wire logic [31:0] bit_cycles,
  output logic [7:0] rx_byte,
  output logic rx_stop,
  output int rx_count
);
  // mid-bit sampling, lsb first; an aborted frame still ends on time
  initial
  begin
    rx_count = 0;
    rx_byte = 8'h00;
    rx_stop = 1'b0;
    forever
    begin
      @(negedge rxd);
      repeat (bit_cycles / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bit_cycles) @(posedge clk);
        rx_byte[i] = rxd;
      end
      repeat (bit_cycles) @(posedge clk);
      rx_stop = rxd;
      rx_count++;
    end
  end
endmodule

// ==== verification/ubg_top_tb.sv ====
// self-checking bench for the baud generator and transmit status
`timescale 1ns/1ps
module ubg_top_tb;
  import ubg_pkg::*;
  logic hclk, hresetn, hsel, hwrite, tmr, hreadyout, hresp, txd, rx_stop;
  logic [1:0] htrans;
  ubg_word_type haddr, hwdata, hrdata, v;
  logic [31:0] bit_cyc;
  logic [7:0] rx_byte;
  int rx_count, base, comparisons, miscompares;
  ubg_top dut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .eight_bit_timer_out(tmr), .txd
  );
  ubg_line_rx peer
  (
    .clk(hclk), .rxd(txd), .bit_cycles(bit_cyc), .rx_byte, .rx_stop, .rx_count
  );
  // clock, and a timer output with a period of eight clock cycles
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always
  begin
    repeat (4) @(posedge hclk);
    tmr <= ~tmr;
  end
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single transfer; read data lands in v
  task automatic bus(input logic w, input logic [15:0] idx,
    input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, {24'h0, d});
  endtask
  task automatic rdc(input string what, input logic [15:0] idx,
    input logic [7:0] exp);
    bus(1'b0, idx, 32'h0);
    check(what, v, {24'h0, exp});
  endtask
  // poll the status until it matches, bounded so a stuck flag shows
  task automatic wait_st(input logic [7:0] exp);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, IDX_TX_STATUS, 32'h0);
      n++;
    end
    while (v !== {24'h0, exp} && n < 2000);
    check("tx_status", v, {24'h0, exp});
  endtask
  // divider and select only change with the unit off
  task automatic setup(input logic [3:0] cs, input logic [7:0] k);
    wr(IDX_MODE, 8'h00);
    wr(IDX_BASE_CLOCK_SELECT, {4'h0, cs});
    wr(IDX_BAUD_DIVIDER, k);
    wr(IDX_MODE, 8'h80);
    wr(IDX_MODE, 8'hc0);
    bit_cyc = (cs == CKSEL_TIMER) ? 32'd16 * k : (32'd2 * k) << cs;
  endtask
  task automatic t_reset;
    rdc("tx_status", IDX_TX_STATUS, 8'h00);
    rdc("clock select", IDX_BASE_CLOCK_SELECT, 8'h00);
    rdc("divider", IDX_BAUD_DIVIDER, 8'hff);
    wr(IDX_TX_STATUS, 8'hff);
    rdc("tx_status", IDX_TX_STATUS, 8'h00);
    rdc("unmapped", 16'hff59, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_stream;
    setup(4'h0, 8'h08);
    base = rx_count;
    wr(IDX_TRANSMIT_BUFFER, 8'ha5);
    wait_st(8'h01);
    wr(IDX_TRANSMIT_BUFFER, 8'h3c);
    wr(IDX_BAUD_DIVIDER, 8'h08);
    rdc("tx_status", IDX_TX_STATUS, 8'h03);
    wait_st(8'h01);
    check("first byte", {24'h0, rx_byte}, 32'ha5);
    wait_st(8'h00);
    check("second byte", {24'h0, rx_byte}, 32'h3c);
    check("frames", rx_count - base, 32'h2);
    $display("stream test done");
  endtask
  // transmit off in mid-frame; the peer then sees a broken frame
  task automatic t_disable;
    wr(IDX_TRANSMIT_BUFFER, 8'h81);
    wait_st(8'h01);
    wr(IDX_TRANSMIT_BUFFER, 8'h7e);
    wr(IDX_MODE, 8'h80);
    rdc("tx_status", IDX_TX_STATUS, 8'h00);
    check("txd", {31'h0, txd}, 32'h1);
    wr(IDX_TRANSMIT_BUFFER, 8'h55);
    rdc("tx_status", IDX_TX_STATUS, 8'h00);
    repeat (400) @(posedge hclk);
    $display("disable test done");
  endtask
  task automatic t_rates;
    logic [3:0] cs [3] = '{4'h0, 4'h1, CKSEL_TIMER};
    logic [7:0] kv [3] = '{8'h09, 8'h08, 8'h08};
    for (int i = 0; i < 3; i++)
    begin
      setup(cs[i], kv[i]);
      base = rx_count;
      wr(IDX_TRANSMIT_BUFFER, 8'h4b + 8'(i));
      wait_st(8'h00);
      check("byte", {24'h0, rx_byte}, 32'h4b + i);
      check("stop", {31'h0, rx_stop}, 32'h1);
      check("frames", rx_count - base, 32'h1);
    end
    $display("rate test done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog, far beyond the few thousand cycles the tests need
  initial
  begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    tmr = 1'b0;
    bit_cyc = 32'h10;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_stream();
    t_disable();
    t_rates();
    stop_test();
  end
endmodule
